// >>> design/dvm_pkg.sv
// constants, command codes and carrier types for the dual integrating voltmeter control
// assumes one 100 MHz system clock; dataway commands arrive already on that clock
package dvm_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int INTEG_TIME_MS = 20;
    localparam int INTEG_CYCLES = INTEG_TIME_MS * 1000 * CLK_MHZ;
    localparam int FULL_SCALE_COUNTS = 512;

    // ****************************************
    // widths and values
    // ****************************************
    localparam int RESULT_W = 10;
    localparam int LEVEL_W = 12;
    localparam int MASK_W = 4;
    localparam int NUM_CONV = 2;
    localparam logic [9:0] RES_POS_FULL = 10'h1ff;
    localparam logic [9:0] RES_NEG_SAT = 10'h200;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam int MASK_DONE_POS = 0;
    localparam int MASK_OVR_POS = 2;

    // ****************************************
    // function codes
    // ****************************************
    localparam logic [4:0] FN_READ = 5'h00;
    localparam logic [4:0] FN_TEST_DONE = 5'h08;
    localparam logic [4:0] FN_TEST_CLEAR = 5'h0a;
    localparam logic [4:0] FN_WRITE_MASK = 5'h11;
    localparam logic [4:0] FN_TEST_BUSY = 5'h1b;
    localparam logic [4:0] FN_START = 5'h1c;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [4:0] func;
        logic [3:0] sub;
        logic [3:0] wdata;
    } cmd_type;

    typedef struct packed {
        logic valid;
        logic q;
        logic [9:0] read;
    } resp_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INTEG = 3'b010,
        ST_DISCH = 3'b100
    } conv_state_type;

endpackage

// >>> design/dual_slope_converter.sv
// one dual-slope conversion sequencer: fixed integrate, then timed run-down
// assumes a digitised stand-in for the integrator level, stable during a conversion
`timescale 1ns/100ps
`default_nettype none
module dual_slope_converter #(
    parameter int INTEG_CYCLES = dvm_pkg::INTEG_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_clear,
    input wire logic i_start,
    input wire logic signed [dvm_pkg::LEVEL_W-1:0] i_level,
    // status
    output logic o_busy,
    output logic o_done,
    output logic o_ovr,
    output logic [dvm_pkg::RESULT_W-1:0] o_result
);
    // ****************************************
    // sequencer
    // ****************************************
    // run-down step: full scale discharges in one integrate period
    localparam int UNIT_RAW = INTEG_CYCLES / dvm_pkg::FULL_SCALE_COUNTS;
    localparam int UNIT_CYCLES = (UNIT_RAW < 1) ? 1 : UNIT_RAW;

    dvm_pkg::conv_state_type state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [9:0] mag_q, mag_d;
    logic [9:0] run_q, run_d;
    logic neg_q, neg_d;
    logic ovr_q, ovr_d;
    logic done_q, done_d;
    logic [9:0] result_q, result_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        mag_d = mag_q;
        run_d = run_q;
        neg_d = neg_q;
        ovr_d = ovr_q;
        done_d = 1'b0;
        result_d = result_q;
        case (state_q)
            dvm_pkg::ST_IDLE: begin
                if (i_start) begin
                    state_d = dvm_pkg::ST_INTEG; // see RULE2
                    cnt_d = 32'h0;
                end
            end
            dvm_pkg::ST_INTEG: begin
                // fixed integrate period, then latch level and clamp to range
                if (cnt_q == 32'(INTEG_CYCLES - 1)) begin // see RULE4
                    state_d = dvm_pkg::ST_DISCH;
                    cnt_d = 32'h0;
                    run_d = 10'h000;
                    neg_d = i_level[dvm_pkg::LEVEL_W-1];
                    if (i_level > 12'sh1ff) begin // see RULE9
                        mag_d = 10'h1ff;
                        ovr_d = 1'b1;
                    end else if (i_level < -12'sh1ff) begin
                        mag_d = 10'h200;
                        ovr_d = 1'b1;
                    end else begin
                        mag_d = i_level[dvm_pkg::LEVEL_W-1] ? 10'(-i_level) : 10'(i_level);
                        ovr_d = 1'b0;
                    end
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            dvm_pkg::ST_DISCH: begin
                // run-down time at constant current gives the magnitude
                if (run_q == mag_q) begin // see RULE5
                    state_d = dvm_pkg::ST_IDLE;
                    done_d = 1'b1;
                    result_d = neg_q ? 10'(-run_q) : run_q; // see RULE8
                end else if (cnt_q == 32'(UNIT_CYCLES - 1)) begin
                    cnt_d = 32'h0;
                    run_d = run_q + 10'h001;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            default: begin
                state_d = dvm_pkg::ST_IDLE;
            end
        endcase
        // initialize aborts a conversion in flight
        if (i_clear) begin
            state_d = dvm_pkg::ST_IDLE;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= dvm_pkg::ST_IDLE;
            cnt_q <= 32'h0;
            mag_q <= 10'h000;
            run_q <= 10'h000;
            neg_q <= 1'b0;
            ovr_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= dvm_pkg::RES_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            mag_q <= mag_d;
            run_q <= run_d;
            neg_q <= neg_d;
            ovr_q <= ovr_d;
            done_q <= done_d;
            result_q <= result_d;
        end
    end

    assign o_busy = (state_q != dvm_pkg::ST_IDLE);
    assign o_done = done_q;
    assign o_ovr = ovr_q;
    assign o_result = result_q;

    // ****************************************
    // checks
    // ****************************************
    logic [31:0] age_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            age_q <= 32'h0;
        end else begin
            age_q <= o_busy ? age_q + 32'h1 : 32'h0;
        end
    end

    a_conv_min_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RULE4
        $rose(done_q) |-> $past(age_q) >= 32'(INTEG_CYCLES))
        else $error("conversion ended before the integrate period");
    a_saturated_code: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RULE9
        $rose(done_q) && ovr_q |-> (result_q == dvm_pkg::RES_POS_FULL) || (result_q == dvm_pkg::RES_NEG_SAT))
        else $error("overrange result not saturated");
    a_sign_code: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RULE8
        $rose(done_q) && !ovr_q |-> result_q != dvm_pkg::RES_NEG_SAT)
        else $error("in-range result used the saturation code");
endmodule
`default_nettype wire

// >>> design/dual_integrating_voltmeter_ctrl.sv
// Contract
// RULE1 - two independent converters; subaddresses 0,2 upper and 1,3 lower.
// RULE2 - function 28 on subaddress 0/1 starts that converter and sets busy.
// RULE3 - external sample pulse starts a conversion exactly like the start command.
// RULE4 - integrate for nominally 20 ms, then time constant-current discharge.
// RULE5 - whole conversion takes 20 to 40 ms depending on input.
// RULE6 - end of conversion sets done; enabled done raises the service request.
// RULE7 - function 0 on subaddress 0/1 returns the result on read lines with Q.
// RULE8 - result is 10-bit two's complement, minus full scale 1000000001.
// RULE9 - beyond range saturates to 0111111111 or 1000000000 and sets overrange.
// RULE10 - function 27 on subaddress 0/1 gives Q exactly while busy.
// RULE11 - function 8 gives Q when done and enabled; flag unchanged.
// RULE12 - function 10 on subaddress 0/1 tests like function 8, clears done.
// RULE13 - function 10 on subaddress 2/3 tests enabled overrange, clears overrange.
// RULE14 - function 17 subaddress 0 loads the four-bit enable mask with Q.
// RULE15 - initialize clears busy, done, overrange and all four enables.
// RULE16 - service request is OR of enabled flags; done ends busy.
//
// top of the two-channel voltmeter control: dataway command decode, flags, enables
// assumes commands and initialize are synchronous to i_clk_sys; sample pins are not
`timescale 1ns/100ps
`default_nettype none
module dual_integrating_voltmeter_ctrl #(
    parameter int INTEG_CYCLES = dvm_pkg::INTEG_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // dataway command side
    input wire logic i_cmd_strobe,
    input wire dvm_pkg::cmd_type i_cmd,
    input wire logic i_init,
    output dvm_pkg::resp_type o_resp,
    output logic o_service_req,
    // front panel and front end
    input wire logic [1:0] i_external_sample_input,
    input wire logic signed [dvm_pkg::LEVEL_W-1:0] i_level_upper,
    input wire logic signed [dvm_pkg::LEVEL_W-1:0] i_level_lower
);
    // ****************************************
    // helpers
    // ****************************************
    // subaddresses 0 and 1 reach done/busy/result, 2 and 3 reach overrange
    function automatic logic low_sub(input logic [3:0] sub);
        return sub < 4'h2;
    endfunction

    function automatic logic is_cmd(input dvm_pkg::cmd_type c, input logic [4:0] fn);
        return c.func == fn;
    endfunction

    // ****************************************
    // external sample synchroniser
    // ****************************************
    // pins are asynchronous; the third stage only feeds the edge detector
    logic [1:0] samp_meta_q, samp_sync_q, samp_last_q;
    logic [1:0] ext_edge;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            samp_meta_q <= 2'h0;
            samp_sync_q <= 2'h0;
            samp_last_q <= 2'h0;
        end else begin
            samp_meta_q <= i_external_sample_input;
            samp_sync_q <= samp_meta_q;
            samp_last_q <= samp_sync_q;
        end
    end

    assign ext_edge = samp_sync_q & ~samp_last_q;

    // ****************************************
    // converters
    // ****************************************
    logic [1:0] conv_start, conv_busy, conv_done, conv_ovr;
    logic [9:0] conv_result [2];
    logic signed [dvm_pkg::LEVEL_W-1:0] conv_level [2];
    logic cmd_start_hit;
    logic cmd_idx;

    assign conv_level[0] = i_level_upper;
    assign conv_level[1] = i_level_lower;
    assign cmd_idx = i_cmd.sub[0]; // see RULE1
    assign cmd_start_hit = i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_START) && low_sub(i_cmd.sub);

    genvar g;
    generate
        for (g = 0; g < dvm_pkg::NUM_CONV; g++) begin : gen_conv
            // both start sources merge into one request
            assign conv_start[g] = (cmd_start_hit && (cmd_idx == 1'(g))) || ext_edge[g]; // see RULE3
            dual_slope_converter #(
                .INTEG_CYCLES(INTEG_CYCLES)
            ) u_conv (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_clear(i_init),
                .i_start(conv_start[g]),
                .i_level(conv_level[g]),
                .o_busy(conv_busy[g]),
                .o_done(conv_done[g]),
                .o_ovr(conv_ovr[g]),
                .o_result(conv_result[g])
            );
        end
    endgenerate

    // ****************************************
    // flags, enables and responses
    // ****************************************
    logic [1:0] done_q, done_d, ovr_q, ovr_d;
    logic [3:0] en_q, en_d;
    dvm_pkg::resp_type resp_q, resp_d;
    logic [1:0] done_clr, ovr_clr;

    always_comb begin
        done_clr = 2'h0;
        ovr_clr = 2'h0;
        en_d = en_q;
        resp_d = '0;
        if (i_cmd_strobe) begin
            resp_d.valid = 1'b1;
            case (i_cmd.func)
                dvm_pkg::FN_READ: begin
                    if (low_sub(i_cmd.sub)) begin
                        resp_d.q = 1'b1; // see RULE7
                        resp_d.read = conv_result[cmd_idx];
                    end
                end
                dvm_pkg::FN_START: begin
                    resp_d.q = low_sub(i_cmd.sub);
                end
                dvm_pkg::FN_TEST_BUSY: begin
                    resp_d.q = low_sub(i_cmd.sub) && conv_busy[cmd_idx]; // see RULE10
                end
                dvm_pkg::FN_TEST_DONE: begin
                    resp_d.q = low_sub(i_cmd.sub) && done_q[cmd_idx] && en_q[dvm_pkg::MASK_DONE_POS + cmd_idx]; // see RULE11
                end
                dvm_pkg::FN_TEST_CLEAR: begin
                    if (low_sub(i_cmd.sub)) begin
                        resp_d.q = done_q[cmd_idx] && en_q[dvm_pkg::MASK_DONE_POS + cmd_idx]; // see RULE12
                        done_clr[cmd_idx] = 1'b1;
                    end else if (i_cmd.sub < 4'h4) begin
                        resp_d.q = ovr_q[cmd_idx] && en_q[dvm_pkg::MASK_OVR_POS + cmd_idx]; // see RULE13
                        ovr_clr[cmd_idx] = 1'b1;
                    end
                end
                dvm_pkg::FN_WRITE_MASK: begin
                    if (i_cmd.sub == 4'h0) begin
                        en_d = i_cmd.wdata; // see RULE14
                        resp_d.q = 1'b1;
                    end
                end
                default: begin
                    resp_d.q = 1'b0;
                end
            endcase
        end
        // a conversion ending in the clearing cycle keeps its flag
        done_d = (done_q & ~done_clr) | conv_done; // see RULE6
        ovr_d = (ovr_q & ~ovr_clr) | (conv_done & conv_ovr); // see RULE9
        if (i_init) begin
            done_d = dvm_pkg::FLAGS_RESET; // see RULE15
            ovr_d = dvm_pkg::FLAGS_RESET;
            en_d = dvm_pkg::MASK_RESET;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_q <= dvm_pkg::FLAGS_RESET;
            ovr_q <= dvm_pkg::FLAGS_RESET;
            en_q <= dvm_pkg::MASK_RESET;
            resp_q <= '0;
        end else begin
            done_q <= done_d;
            ovr_q <= ovr_d;
            en_q <= en_d;
            resp_q <= resp_d;
        end
    end

    assign o_resp = resp_q;
    // busy ends in the same edge that sets done, inside the converter
    assign o_service_req = |({ovr_q, done_q} & en_q); // see RULE16

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_start_sets_busy: assert property ( // see RULE2
        cmd_start_hit && !cmd_idx && !conv_busy[0] && !i_init |=> conv_busy[0] [*8])
        else $error("start command did not hold busy");
    a_ext_sets_busy: assert property ( // see RULE3
        ext_edge[1] && !conv_busy[1] && !i_init |=> conv_busy[1])
        else $error("external sample did not start lower converter");
    a_done_sets_flag: assert property ( // see RULE6
        conv_done[0] && !i_init && !conv_start[0] |=> done_q[0] && !conv_busy[0])
        else $error("done flag not set at end of conversion");
    a_read_returns: assert property ( // see RULE7
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_READ) && i_cmd.sub == 4'h1
        |=> o_resp.valid && o_resp.q && o_resp.read == $past(conv_result[1]))
        else $error("read of lower result wrong");
    a_busy_test_q: assert property ( // see RULE10
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_TEST_BUSY) && i_cmd.sub == 4'h0
        |=> o_resp.q == $past(conv_busy[0]))
        else $error("busy test answer wrong");
    a_test_keeps_done: assert property ( // see RULE11
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_TEST_DONE) && i_cmd.sub == 4'h0 && !i_init && !conv_done[0]
        |=> done_q[0] == $past(done_q[0]) && o_resp.q == $past(done_q[0] && en_q[0]))
        else $error("done test changed the flag or answered wrong");
    a_clear_done: assert property ( // see RULE12
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_TEST_CLEAR) && i_cmd.sub == 4'h1 && !conv_done[1]
        |=> !done_q[1] && o_resp.q == $past(done_q[1] && en_q[1]))
        else $error("done clear test wrong");
    a_clear_ovr: assert property ( // see RULE13
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_TEST_CLEAR) && i_cmd.sub == 4'h2 && !conv_done[0]
        |=> !ovr_q[0] && o_resp.q == $past(ovr_q[0] && en_q[2]))
        else $error("overrange clear test wrong");
    a_mask_load: assert property ( // see RULE14
        i_cmd_strobe && is_cmd(i_cmd, dvm_pkg::FN_WRITE_MASK) && i_cmd.sub == 4'h0 && !i_init
        |=> en_q == $past(i_cmd.wdata) && o_resp.q)
        else $error("enable mask not loaded");
    a_init_clears: assert property ( // see RULE15
        i_init |=> done_q == 2'h0 && ovr_q == 2'h0 && en_q == 4'h0 && conv_busy == 2'h0 && !o_service_req)
        else $error("initialize left state behind");
    a_request_follows: assert property ( // see RULE16
        $rose(done_q[1]) && en_q[1] |-> o_service_req)
        else $error("enabled done did not raise service request");
endmodule
`default_nettype wire

// >>> testbench/crate_ctrl_model.sv
// crate controller stand-in: dataway commands, initialize and front-panel sample pulses
// assumes the bench calls its tasks from one process, on the system clock
`timescale 1ns/100ps
`default_nettype none
module crate_ctrl_model (
    // clock
    input wire logic i_clk_sys,
    // dataway
    output logic o_cmd_strobe,
    output dvm_pkg::cmd_type o_cmd,
    output logic o_init,
    // front panel
    output logic [1:0] o_sample
);
    logic [12:0] junk_q = 13'h0a5a;

    initial begin
        o_cmd_strobe = 1'b0;
        o_cmd = '0;
        o_init = 1'b0;
        o_sample = 2'h0;
    end

    // ****************************************
    // commands
    // ****************************************
    // strobe held across calls, so commands may run back to back
    task automatic send(input logic [4:0] f, input logic [3:0] s, input logic [3:0] w);
        @(posedge i_clk_sys);
        #1;
        o_cmd_strobe = 1'b1;
        o_cmd = '{func: f, sub: s, wdata: w};
    endtask

    // released command lines show a changing pattern, never the last command
    task automatic release_bus();
        @(posedge i_clk_sys);
        #1;
        o_cmd_strobe = 1'b0;
        junk_q = ~junk_q ^ {junk_q[11:0], junk_q[12]};
        o_cmd = junk_q;
    endtask

    task automatic pulse_init();
        @(posedge i_clk_sys);
        #1;
        o_init = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_init = 1'b0;
    endtask

    // pulse kept well above the synchroniser's two stages
    task automatic sample(input int k);
        @(posedge i_clk_sys);
        #1;
        o_sample[k] = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        o_sample[k] = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the two-channel voltmeter control
// assumes the crate controller model drives all dataway and panel inputs
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // short integrate so a run stays small; run-down step is INTEG/512
    localparam int INTEG = 1024;
    localparam int CONV_WAIT = INTEG + 2 * 1024 + 40;
    logic i_clk_sys;
    logic i_rst_n;
    logic strobe;
    logic init;
    logic sreq;
    logic [1:0] sample;
    dvm_pkg::cmd_type cmd;
    dvm_pkg::resp_type resp;
    logic signed [11:0] lvl_up;
    logic signed [11:0] lvl_lo;
    logic [10:0] exp_q[$];
    int n_errors = 0;
    int checks = 0;
    logic [31:0] seed = 32'hb21e4a48;

    crate_ctrl_model u_ctrl (.i_clk_sys(i_clk_sys), .o_cmd_strobe(strobe), .o_cmd(cmd), .o_init(init),
        .o_sample(sample));
    dual_integrating_voltmeter_ctrl #(.INTEG_CYCLES(INTEG)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_cmd_strobe(strobe), .i_cmd(cmd), .i_init(init), .o_resp(resp), .o_service_req(sreq),
        .i_external_sample_input(sample), .i_level_upper(lvl_up), .i_level_lower(lvl_lo));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd_exp(input logic [4:0] f, input logic [3:0] s, input logic [3:0] w, input logic [10:0] e);
        exp_q.push_back(e);
        u_ctrl.send(f, s, w);
    endtask

    task automatic finish_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one response per command, oldest note first
    always @(negedge i_clk_sys) begin
        if (resp.valid === 1'b1) begin
            // a response with no note is always a mismatch
            if (exp_q.size() == 0) begin
                check({resp.q, resp.read}, ~{resp.q, resp.read});
            end else begin
                check({resp.q, resp.read}, exp_q.pop_front());
            end
        end
    end

    // ****************************************
    // one conversion with a given mask, then flag tests and clears
    // ****************************************
    task automatic run_conv(input int idx, input logic signed [11:0] lvl, input logic [3:0] m);
        int k;
        logic ovr;
        logic [9:0] res;
        k = idx % 2;
        ovr = (lvl > 511) || (lvl < -511);
        res = (lvl > 511) ? 10'h1ff : (lvl < -511) ? 10'h200 : lvl[9:0];
        lvl_up = (k == 0) ? lvl : 12'(int'(xs() % 32'd1023) - 511);
        lvl_lo = (k == 1) ? lvl : 12'(int'(xs() % 32'd1023) - 511);
        cmd_exp(dvm_pkg::FN_WRITE_MASK, 4'h0, m, 11'h400);
        if (k == 1) begin
            u_ctrl.release_bus();
            u_ctrl.sample(k);
        end else begin
            cmd_exp(dvm_pkg::FN_START, 4'(k), 4'(xs()), 11'h400);
        end
        cmd_exp(dvm_pkg::FN_TEST_BUSY, 4'(k), 4'(xs()), 11'h400);
        cmd_exp(dvm_pkg::FN_TEST_BUSY, 4'(1 - k), 4'(xs()), 11'h000);
        u_ctrl.release_bus();
        repeat (CONV_WAIT) @(posedge i_clk_sys);
        cmd_exp(dvm_pkg::FN_TEST_BUSY, 4'(k), 4'(xs()), 11'h000);
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'(k), 4'(xs()), {m[k], 10'h0});
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'(k), 4'(xs()), {m[k], 10'h0});
        u_ctrl.release_bus();
        @(posedge i_clk_sys);
        #1;
        check({10'h0, sreq}, {10'h0, m[k] | (ovr & m[k + 2])});
        cmd_exp(dvm_pkg::FN_READ, 4'(k), 4'(xs()), {1'b1, res});
        cmd_exp(dvm_pkg::FN_TEST_CLEAR, 4'(k), 4'(xs()), {m[k], 10'h0});
        cmd_exp(dvm_pkg::FN_TEST_CLEAR, 4'(k + 2), 4'(xs()), {ovr & m[k + 2], 10'h0});
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'(k), 4'(xs()), 11'h000);
        cmd_exp(dvm_pkg::FN_TEST_CLEAR, 4'(k + 2), 4'(xs()), 11'h000);
        u_ctrl.release_bus();
        @(posedge i_clk_sys);
        #1;
        check({10'h0, sreq}, 11'h000);
    endtask

    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        repeat (40000) @(posedge i_clk_sys);
        n_errors++;
        finish_test();
    end

    initial begin
        logic signed [11:0] lvls [5];
        logic [3:0] masks [5];
        i_rst_n = 1'b0;
        lvl_up = 12'h000;
        lvl_lo = 12'h000;
        lvls = '{12'(int'(xs() % 32'd1023) - 511), 12'sd600, -12'sd600, -12'sd511, 12'sd0};
        masks = '{4'hf, 4'hf, 4'h3, 4'hc, 4'hf};
        repeat (10) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'h0, 4'h0, 11'h000);
        cmd_exp(dvm_pkg::FN_TEST_BUSY, 4'h1, 4'h0, 11'h000);
        u_ctrl.release_bus();
        for (int i = 0; i < 5; i++) begin
            run_conv(i, lvls[i], masks[i]);
        end
        // initialize with upper flags standing and the lower converter in flight
        lvl_up = 12'sd700;
        cmd_exp(dvm_pkg::FN_WRITE_MASK, 4'h0, 4'hf, 11'h400);
        cmd_exp(dvm_pkg::FN_START, 4'h0, 4'h0, 11'h400);
        u_ctrl.release_bus();
        repeat (CONV_WAIT) @(posedge i_clk_sys);
        #1;
        check({10'h0, sreq}, 11'h001);
        cmd_exp(dvm_pkg::FN_START, 4'h1, 4'h0, 11'h400);
        u_ctrl.release_bus();
        repeat (20) @(posedge i_clk_sys);
        u_ctrl.pulse_init();
        check({10'h0, sreq}, 11'h000);
        cmd_exp(dvm_pkg::FN_TEST_BUSY, 4'h1, 4'h0, 11'h000);
        cmd_exp(dvm_pkg::FN_WRITE_MASK, 4'h1, 4'h5, 11'h000);
        // mask back on, so the tests below see the cleared flags themselves
        cmd_exp(dvm_pkg::FN_WRITE_MASK, 4'h0, 4'hf, 11'h400);
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'h0, 4'h0, 11'h000);
        cmd_exp(dvm_pkg::FN_TEST_CLEAR, 4'h2, 4'h0, 11'h000);
        u_ctrl.release_bus();
        repeat (CONV_WAIT) @(posedge i_clk_sys);
        cmd_exp(dvm_pkg::FN_TEST_DONE, 4'h1, 4'h0, 11'h000);
        u_ctrl.release_bus();
        @(posedge i_clk_sys);
        #1;
        check({10'h0, sreq}, 11'h000);
        repeat (4) @(posedge i_clk_sys);
        check(11'(exp_q.size()), 11'h000);
        finish_test();
    end
endmodule
`default_nettype wire
